/* sim/spx_peer.sv */
// Remote serial peer: sends frames on the receive line, samples the transmit line
`timescale 1ns/1ps
module spx_peer (
  input wire logic clk_sys_i,
  input wire logic tick_i,
  input wire logic txd_i,
  output logic rxd_o
);
  // Line idles high, as with a pull-up
  initial rxd_o = 1'h1;
  // One bit per tick, start bit first; the line goes back to idle afterwards
  task automatic send(input logic [11:0] f, input int cnt);
    for (int j = 0; j < cnt; j++)
    begin
      @(posedge clk_sys_i iff tick_i);
      rxd_o <= f[j];
    end
    @(posedge clk_sys_i iff tick_i);
    rxd_o <= 1'h1;
  endtask : send
  // Waits for a start bit, then samples two cycles after each tick
  task automatic recv(output logic [11:0] f, input int cnt);
    f = 12'hfff;
    @(posedge clk_sys_i iff txd_i === 1'h0);
    f[0] = 1'h0;
    for (int j = 1; j < cnt; j++)
    begin
      @(posedge clk_sys_i iff tick_i);
      repeat (2) @(posedge clk_sys_i);
      f[j] = txd_i;
    end
  endtask : recv
endmodule : spx_peer

/* sim/test_serial_port_tx_rx_datapath.sv */
// Self-checking bench for the serial port data path
`timescale 1ns/1ps
module test_serial_port_tx_rx_datapath;
  logic clk_sys_i = 1'h0;
  logic rst_i = 1'h1;
  logic bit_tick_i = 1'h0;
  logic sync_mode_i = 1'h0; // Last pass is timed by the transfer clock pin
  logic sync_transfer_clock_pin_i = 1'h0;
  logic [2:0] char_size_code_i = 3'h0;
  logic parity_enable_bit_i = 1'h0;
  logic parity_odd_i = 1'h0;
  logic stop2_i = 1'h0;
  logic tx_enable_bit_i = 1'h1;
  logic ien = 1'h1; // Both interrupt enables
  logic tx_write_i = 1'h0;
  logic [8:0] wd = 9'h000; // Ninth bit and byte of a write
  logic tx_complete_clear_i = 1'h0;
  logic tx_complete_irq_ack_i = 1'h0;
  logic rx_read_i = 1'h0;
  logic rxd_i;
  logic txd_o, tx_pin_override_o, rx_pin_override_o, tx_buffer_empty_flag_o;
  logic tx_complete_flag_o, tx_empty_irq_o, tx_complete_irq_o, rx_complete_flag_o;
  logic rx_ninth_bit_o, frame_error_flag_o, overrun_flag_o, parity_error_flag_o;
  logic [7:0] rx_data_o;
  logic [11:0] seen, fa, fb;
  logic [8:0] db;
  logic fea, pb;
  int fails = 0;
  int total_checks = 0;
  int tmr = 0;
  int n, i, k;
  // Design under test; strobe masked in sync mode, so only the pin can time bits
  spx_core u_spx_core (.clk_sys_i, .rst_i, .bit_tick_i(bit_tick_i && !sync_mode_i),
    .sync_mode_i, .sync_transfer_clock_pin_i, .char_size_code_i, .parity_enable_bit_i,
    .parity_odd_i, .stop2_i, .tx_enable_bit_i, .rx_enable_bit_i(1'h1),
    .tx_empty_irq_enable_i(ien), .tx_complete_irq_enable_i(ien), .tx_ninth_bit_i(wd[8]),
    .tx_write_i, .tx_data_i(wd[7:0]), .tx_complete_clear_i, .tx_complete_irq_ack_i,
    .rx_read_i, .rxd_i, .txd_o, .tx_pin_override_o, .rx_pin_override_o,
    .tx_buffer_empty_flag_o, .tx_complete_flag_o, .tx_empty_irq_o, .tx_complete_irq_o,
    .rx_complete_flag_o, .rx_data_o, .rx_ninth_bit_o, .frame_error_flag_o,
    .overrun_flag_o, .parity_error_flag_o);
  spx_peer u_spx_peer (.clk_sys_i, .tick_i(bit_tick_i), .txd_i(txd_o), .rxd_o(rxd_i));
  // 200 MHz clock
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  // Bit strobe every eight cycles keeps frames short
  always @(posedge clk_sys_i)
  begin
    tmr <= (tmr + 1) % 8;
    bit_tick_i <= (tmr == 7);
    // Pin high for the first half bit: rise matches the strobe, fall samples mid-bit
    sync_transfer_clock_pin_i <= ((tmr + 1) % 8) < 4;
  end
  // Counts every compare, reports a differing one at once
  task automatic check(input logic [11:0] s, input logic [11:0] e, input string m);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask : check
  // Expected line bits: start, data LSB first, parity, then idle ones
  function automatic logic [11:0] frame(input logic [8:0] d, input int nb, input logic pen,
    input logic odd);
    logic [11:0] f;
    logic p;
    f = 12'hffe;
    p = odd;
    for (int j = 0; j < nb; j++)
    begin
      f[j + 1] = d[j];
      p = p ^ d[j];
    end
    if (pen)
    begin
      f[nb + 1] = p;
    end
    return f;
  endfunction : frame
  // Status and ninth bit compared before the pop, as software must
  task automatic take(input logic [8:0] d, input logic fe_x, input logic pe_x,
    input logic ov_x);
    check({4'h0, rx_data_o}, {4'h0, d[7:0] & (8'hff >> (8 - (n > 8 ? 8 : n)))}, "data");
    check({11'h0, rx_ninth_bit_o}, {11'h0, n == 9 && d[8]}, "ninth");
    check({9'h0, frame_error_flag_o, parity_error_flag_o, overrun_flag_o},
      {9'h0, fe_x, pe_x, ov_x}, "status");
    @(posedge clk_sys_i);
    rx_read_i <= 1'h1;
    @(posedge clk_sys_i);
    rx_read_i <= 1'h0;
    #1;
  endtask : take
  // Prints counts and verdict, then stops
  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog well beyond the few thousand cycles the tests need
  initial
  begin
    #100000;
    fails++;
    complete_run();
  end
  // Main sequence: size codes 0 to 3, 7 and 5, transmit then receive
  initial
  begin
    void'($urandom(53));
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    @(posedge clk_sys_i);
    #1 check({8'h0, txd_o, tx_buffer_empty_flag_o, tx_complete_flag_o, rx_pin_override_o},
      12'hd, "reset state");
    for (k = 0; k < 6; k++)
    begin
      @(posedge clk_sys_i);
      char_size_code_i <= (k == 4) ? 3'h7 : k[2:0];
      sync_mode_i <= (k == 5);
      parity_enable_bit_i <= 1'($urandom);
      parity_odd_i <= 1'($urandom);
      stop2_i <= 1'($urandom);
      wd <= 9'($urandom);
      @(posedge clk_sys_i);
      n = (k == 4) ? 9 : 5 + k % 4;
      #1 check({11'h0, tx_empty_irq_o}, 12'h1, "empty request");
      @(posedge clk_sys_i);
      fork
        u_spx_peer.recv(seen, n + 2 + parity_enable_bit_i);
        begin
          tx_write_i <= 1'h1;
          @(posedge clk_sys_i);
          tx_write_i <= 1'h0;
          tx_enable_bit_i <= (k != 2);
          #1 check({11'h0, tx_buffer_empty_flag_o}, 12'h0, "empty after write");
        end
      join
      check(seen, frame(wd, n, parity_enable_bit_i, parity_odd_i), "tx frame");
      for (i = 0; i < 200 && tx_complete_flag_o !== 1'h1; i++) @(posedge clk_sys_i);
      #1 check({10'h0, tx_complete_flag_o, tx_complete_irq_o}, 12'h3, "complete");
      repeat (2) @(posedge clk_sys_i);
      #1 check({10'h0, tx_pin_override_o, txd_o}, {10'h0, k != 2, 1'h1}, "release");
      @(posedge clk_sys_i);
      tx_complete_clear_i <= k[0];
      tx_complete_irq_ack_i <= !k[0];
      @(posedge clk_sys_i);
      tx_complete_clear_i <= 1'h0;
      tx_complete_irq_ack_i <= 1'h0;
      tx_enable_bit_i <= 1'h1;
      #1 check({10'h0, tx_complete_flag_o, tx_complete_irq_o}, 12'h0, "cleared");
      // Receive: first frame may carry a bad stop or parity bit
      fa = frame(wd, n, parity_enable_bit_i, parity_odd_i);
      fea = 1'($urandom);
      pb = parity_enable_bit_i & 1'($urandom);
      fa[n + 1 + parity_enable_bit_i] = !fea;
      fa[n + 1] = fa[n + 1] ^ pb;
      db = 9'($urandom);
      fb = frame(db, n, parity_enable_bit_i, parity_odd_i);
      u_spx_peer.send(fa, n + 2 + parity_enable_bit_i);
      // Copies of the second frame: one fills the buffer, one waits, one overruns
      repeat (3) u_spx_peer.send(fb, n + 2 + parity_enable_bit_i);
      repeat (6) @(posedge clk_sys_i);
      #1 check({11'h0, rx_complete_flag_o}, 12'h1, "rx ready");
      take(wd, fea, pb, 1'h0);
      take(db, 1'h0, 1'h0, 1'h0);
      take(db, 1'h0, 1'h0, 1'h1);
      check({11'h0, rx_complete_flag_o}, 12'h0, "rx empty");
      $display("Size code %0d done", char_size_code_i);
    end
    complete_run();
  end
endmodule : test_serial_port_tx_rx_datapath

/* src/spx_core.sv */
// Serial port transmit and receive data path, top level
`timescale 1ns/1ps
module spx_core #(
  parameter int RX_DEPTH = spx_pkg::RX_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic bit_tick_i,
  input wire logic sync_mode_i,
  input wire logic sync_transfer_clock_pin_i,
  input wire logic [2:0] char_size_code_i,
  input wire logic parity_enable_bit_i,
  input wire logic parity_odd_i,
  input wire logic stop2_i,
  input wire logic tx_enable_bit_i,
  input wire logic rx_enable_bit_i,
  input wire logic tx_empty_irq_enable_i,
  input wire logic tx_complete_irq_enable_i,
  input wire logic tx_ninth_bit_i,
  input wire logic tx_write_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_complete_clear_i,
  input wire logic tx_complete_irq_ack_i,
  input wire logic rx_read_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic tx_pin_override_o,
  output logic rx_pin_override_o,
  output logic tx_buffer_empty_flag_o,
  output logic tx_complete_flag_o,
  output logic tx_empty_irq_o,
  output logic tx_complete_irq_o,
  output logic rx_complete_flag_o,
  output logic [7:0] rx_data_o,
  output logic rx_ninth_bit_o,
  output logic frame_error_flag_o,
  output logic overrun_flag_o,
  output logic parity_error_flag_o
);
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(RX_DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  spx_link_if lk ();

  // Transfer clock pin history for edge detection
  logic tpin_q;
  // Transmit buffer
  logic buf_full;
  logic [8:0] buf_word;
  logic next_buf_full;
  // Transmitter owns the pin
  logic tx_active;
  // Complete flag next value
  logic next_txc;
  // Receive buffer entries and fill level
  spx_pkg::spx_rx_entry_s fifo [RX_DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] wr_slot;
  // Finished frame still in the shift stage
  spx_pkg::spx_rx_entry_s pend;
  logic pend_v;
  logic ovr_pend;
  // Buffer strobes
  logic rd;
  logic push;
  logic flush;

  // Shifters
  spx_tx_shift u_tx (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .lk(lk.tx)
  );

  spx_rx_shift u_rx (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .lk(lk.rx)
  );

  // Frame format; size and parity shared by both directions, stop count used by transmit only
  assign lk.nbits = spx_pkg::spx_nbits(char_size_code_i);
  assign lk.par_en = parity_enable_bit_i;
  assign lk.par_odd = parity_odd_i;
  assign lk.stop2 = stop2_i;

  // Bit strobes; in synchronous mode the pin edges time bits
  // Data changes on the rising edge and is sampled on the falling one
  assign lk.tick_tx = sync_mode_i ? (sync_transfer_clock_pin_i && !tpin_q)
                                  : bit_tick_i;
  assign lk.tick_rx = sync_mode_i ? (!sync_transfer_clock_pin_i && tpin_q)
                                  : bit_tick_i;

  // Receiver reads the pin only while enabled
  assign lk.rx_en = rx_enable_bit_i;
  assign lk.rxd = rx_enable_bit_i ? rxd_i : spx_pkg::LINE_IDLE;

  // Transfer clock pin history
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      tpin_q <= 1'h0;
    end
    else
    begin
      tpin_q <= sync_transfer_clock_pin_i;
    end
  end

  // Shifter takes the buffer when idle, also right after a stop bit
  assign lk.tx_load = buf_full && !lk.tx_busy && tx_active;
  assign lk.tx_word = buf_word;

  // Buffer fill: a write fills it, a load empties it
  assign next_buf_full = tx_write_i || (buf_full && !lk.tx_load);

  // Transmit buffer
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      buf_full <= 1'h0;
      buf_word <= '0;
    end
    else
    begin
      buf_full <= next_buf_full;
      if (tx_write_i)
      begin
        // Ninth bit is caught with the low byte
        buf_word <= {tx_ninth_bit_i, tx_data_i};
      end
    end
  end

  // Empty flag and its level request
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      tx_buffer_empty_flag_o <= 1'h1;
      tx_empty_irq_o <= 1'h0;
    end
    else
    begin
      tx_buffer_empty_flag_o <= !next_buf_full;
      tx_empty_irq_o <= !next_buf_full && tx_empty_irq_enable_i;
    end
  end

  // Set beats both clears in the same cycle
  assign next_txc = (lk.tx_done && !buf_full) ||
                    (tx_complete_flag_o && !tx_complete_clear_i &&
                     !tx_complete_irq_ack_i);

  // Complete flag and its request
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      tx_complete_flag_o <= 1'h0;
      tx_complete_irq_o <= 1'h0;
    end
    else
    begin
      tx_complete_flag_o <= next_txc;
      tx_complete_irq_o <= next_txc && tx_complete_irq_enable_i;
    end
  end

  // Pin ownership; a disable waits for pending data
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      tx_active <= 1'h0;
    end
    else if (tx_enable_bit_i)
    begin
      tx_active <= 1'h1;
    end
    else if (!buf_full && !lk.tx_busy)
    begin
      tx_active <= 1'h0;
    end
  end

  // Pin drive, high when no frame runs
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      txd_o <= spx_pkg::LINE_IDLE;
      tx_pin_override_o <= 1'h0;
      rx_pin_override_o <= 1'h0;
    end
    else
    begin
      txd_o <= tx_active ? lk.tx_line : spx_pkg::LINE_IDLE;
      tx_pin_override_o <= tx_active;
      rx_pin_override_o <= rx_enable_bit_i;
    end
  end

  // Receive buffer strobes; status must be read first
  assign flush = !rx_enable_bit_i;
  assign rd = rx_read_i && (count != '0);
  assign wr_slot = count - (rd ? ONE : '0);
  // Waiting frame moves in as soon as a slot frees
  assign push = pend_v && (wr_slot != FULL);
  assign next_count = flush ? '0 : wr_slot + (push ? ONE : '0);

  // Frame waiting in the shift stage, overrun tracking
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || flush)
    begin
      pend <= '0;
      pend_v <= 1'h0;
      ovr_pend <= 1'h0;
    end
    else
    begin
      if (lk.rx_done)
      begin
        // Upper bits cleared for short characters
        pend.data <= lk.rx_word[7:0] & spx_pkg::spx_mask(lk.nbits);
        pend.ninth <= (lk.nbits == spx_pkg::DBITS_NINE) && lk.rx_word[8];
        pend.fe <= lk.rx_fe;
        pend.pe <= lk.rx_pe && parity_enable_bit_i;
        pend.ovr <= 1'h0;
        pend_v <= 1'h1;
      end
      else if (push)
      begin
        pend_v <= 1'h0;
      end
      // Buffer full, one waiting and a new start: data will be lost
      if (lk.rx_start && count == FULL && pend_v)
      begin
        ovr_pend <= 1'h1;
      end
      else if (push)
      begin
        ovr_pend <= 1'h0;
      end
    end
  end

  // Buffer entries; reads shift toward the head
  for (genvar i = 0; i < RX_DEPTH; i++)
  begin : g_ent
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i || flush)
      begin
        fifo[i] <= '0;
      end
      else if (push && wr_slot == CW'(i))
      begin
        fifo[i] <= '{ninth: pend.ninth, data: pend.data, fe: pend.fe,
                     ovr: ovr_pend, pe: pend.pe};
      end
      else if (rd)
      begin
        if (i + 1 < RX_DEPTH)
        begin
          fifo[i] <= fifo[(i + 1) % RX_DEPTH];
        end
        else
        begin
          fifo[i] <= '0;
        end
      end
    end
  end

  // Fill level and unread data flag
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      count <= '0;
      rx_complete_flag_o <= 1'h0;
    end
    else
    begin
      count <= next_count;
      rx_complete_flag_o <= (next_count != '0);
    end
  end

  // Head entry drives the read side straight from its flops
  assign rx_data_o = fifo[0].data;
  assign rx_ninth_bit_o = fifo[0].ninth;
  assign frame_error_flag_o = fifo[0].fe;
  assign overrun_flag_o = fifo[0].ovr;
  assign parity_error_flag_o = fifo[0].pe;

  // Checks on the data path
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // A write is followed by a full buffer
  sequence s_write;
    tx_write_i;
  endsequence

  // Last stop bit out with nothing waiting
  sequence s_last_frame;
    lk.tx_done && !buf_full;
  endsequence

  a_write_clears_empty: assert property (
    s_write |=> !tx_buffer_empty_flag_o && buf_full)
    else $error("empty flag not cleared by a write");

  a_empty_irq_level: assert property (
    tx_empty_irq_enable_i && !tx_write_i && !buf_full |=> tx_empty_irq_o)
    else $error("empty request dropped while flag set");

  a_txc_sets: assert property (
    s_last_frame |=> tx_complete_flag_o ##0 (tx_complete_irq_o ||
      !$past(tx_complete_irq_enable_i)))
    else $error("complete flag not set after last frame");

  a_txc_write_one: assert property (
    tx_complete_flag_o && tx_complete_clear_i && !lk.tx_done |=> !tx_complete_flag_o)
    else $error("complete flag not cleared by a one");

  a_txc_holds: assert property (
    tx_complete_flag_o && !tx_complete_clear_i && !tx_complete_irq_ack_i
      |=> tx_complete_flag_o)
    else $error("complete flag lost without a clear");

  a_tx_disable_waits: assert property (
    tx_active && !tx_enable_bit_i && (buf_full || lk.tx_busy) |=> tx_active [*1])
    else $error("transmitter released with data pending");

  a_load_when_idle: assert property (
    lk.tx_load |-> !lk.tx_busy ##1 (lk.tx_busy && (!buf_full || $past(tx_write_i))))
    else $error("shifter loaded while busy");

  a_idle_line_high: assert property (
    tx_active && !lk.tx_busy && $past(!lk.tx_busy) |=> txd_o)
    else $error("line not high while idle");

  a_frame_moves_in: assert property (
    lk.rx_done |=> pend_v ##[0:2] (count != '0) || !rx_enable_bit_i)
    else $error("finished frame not buffered");

  a_rxc_matches: assert property (
    rx_complete_flag_o == (count != '0))
    else $error("receive flag does not match buffer");

  a_overrun_mark: assert property (
    lk.rx_start && count == FULL && pend_v && rx_enable_bit_i |=> ovr_pend)
    else $error("overrun not recorded");

  a_short_char_zero: assert property (
    rx_complete_flag_o && lk.nbits < spx_pkg::DBITS_EIGHT
      |-> (rx_data_o & ~spx_pkg::spx_mask(lk.nbits)) == 8'h00 || $changed(lk.nbits))
    else $error("upper data bits not zero");

endmodule : spx_core

/* src/spx_link_if.sv */
// Signals between the serial port core and its shifters
`timescale 1ns/1ps
interface spx_link_if;
  logic tick_tx;      // Transmit bit strobe
  logic tick_rx;      // Receive sample strobe
  logic [3:0] nbits;  // Data bits per frame
  logic par_en;       // Parity on
  logic par_odd;      // Odd parity
  logic stop2;        // Two stop bits on transmit
  logic tx_load;      // Buffer into shifter
  logic [8:0] tx_word; // Character to send
  logic tx_busy;      // Frame in progress
  logic tx_done;      // Last stop bit gone
  logic tx_line;      // Serial output level
  logic rxd;          // Serial input level
  logic rx_en;        // Receiver on
  logic rx_start;     // Start bit seen
  logic rx_done;      // First stop bit taken
  logic [8:0] rx_word; // Received character
  logic rx_fe;        // Stop bit was low
  logic rx_pe;        // Parity mismatch
  modport ctl (output tick_tx, tick_rx, nbits, par_en, par_odd, stop2, tx_load,
    tx_word, rxd, rx_en, input tx_busy, tx_done, tx_line, rx_start, rx_done,
    rx_word, rx_fe, rx_pe);
  modport tx (input tick_tx, nbits, par_en, par_odd, stop2, tx_load, tx_word,
    output tx_busy, tx_done, tx_line);
  modport rx (input tick_rx, nbits, par_en, par_odd, rxd, rx_en,
    output rx_start, rx_done, rx_word, rx_fe, rx_pe);
endinterface : spx_link_if

/* src/spx_pkg.sv */
// Shared constants, types and helpers of the serial port data path
package spx_pkg;
  // Receive buffer depth in characters
  localparam int RX_DEPTH = 2;
  // Character size code that selects nine data bits
  localparam logic [2:0] CSZ_NINE = 3'h7;
  // Data bit counts
  localparam logic [3:0] DBITS_BASE = 4'h5;
  localparam logic [3:0] DBITS_EIGHT = 4'h8;
  localparam logic [3:0] DBITS_NINE = 4'h9;
  // Line level while idle
  localparam logic LINE_IDLE = 1'h1;
  // Frame sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PAR = 5'h08,
    ST_STOP = 5'h10
  } spx_state_e;
  // One receive buffer entry with its own status
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
    logic fe;
    logic ovr;
    logic pe;
  } spx_rx_entry_s;
  // Data bits in a frame for a size code
  function automatic logic [3:0] spx_nbits(input logic [2:0] code);
    return (code == CSZ_NINE) ? DBITS_NINE : DBITS_BASE + {2'h0, code[1:0]};
  endfunction : spx_nbits
  // Mask of the valid low data bits
  function automatic logic [7:0] spx_mask(input logic [3:0] n);
    logic [7:0] m;
    m = 8'hff;
    if (n < DBITS_EIGHT)
    begin
      m = 8'hff >> (DBITS_EIGHT - n);
    end
    return m;
  endfunction : spx_mask
endpackage : spx_pkg

/* src/spx_rx_shift.sv */
// Receive shift register and frame sequencer
`timescale 1ns/1ps
module spx_rx_shift (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  spx_link_if.rx lk
);
  spx_pkg::spx_state_e st; // Sequencer state
  logic [8:0] sh;          // Bits taken so far
  logic [3:0] cnt;         // Bit counter
  logic par;               // Running parity

  // Sampler; disabling drops a frame at once
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !lk.rx_en)
    begin
      st <= spx_pkg::ST_IDLE;
      sh <= '0;
      cnt <= '0;
      par <= 1'h0;
      lk.rx_start <= 1'h0;
      lk.rx_done <= 1'h0;
      lk.rx_word <= '0;
      lk.rx_fe <= 1'h0;
      lk.rx_pe <= 1'h0;
    end
    else
    begin
      lk.rx_start <= 1'h0;
      lk.rx_done <= 1'h0;
      case (st)
        spx_pkg::ST_IDLE:
        begin
          // Only a low sample starts a frame
          if (lk.tick_rx && !lk.rxd)
          begin
            lk.rx_start <= 1'h1;
            cnt <= '0;
            par <= lk.par_odd;
            lk.rx_pe <= 1'h0;
            st <= spx_pkg::ST_DATA;
          end
        end
        spx_pkg::ST_DATA:
        begin
          if (lk.tick_rx)
          begin
            // Shift in from the top
            sh <= {lk.rxd, sh[8:1]};
            par <= par ^ lk.rxd;
            cnt <= cnt + 4'h1;
            if (cnt == lk.nbits - 4'h1)
            begin
              st <= lk.par_en ? spx_pkg::ST_PAR : spx_pkg::ST_STOP;
            end
          end
        end
        spx_pkg::ST_PAR:
        begin
          if (lk.tick_rx)
          begin
            lk.rx_pe <= (par != lk.rxd);
            st <= spx_pkg::ST_STOP;
          end
        end
        spx_pkg::ST_STOP:
        begin
          // First stop bit ends the frame, a second is ignored
          if (lk.tick_rx)
          begin
            lk.rx_done <= 1'h1;
            lk.rx_fe <= !lk.rxd;
            lk.rx_word <= sh >> (spx_pkg::DBITS_NINE - lk.nbits);
            st <= spx_pkg::ST_IDLE;
          end
        end
        default:
        begin
          st <= spx_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule : spx_rx_shift

/* src/spx_tx_shift.sv */
// Transmit shift register and frame sequencer
`timescale 1ns/1ps
module spx_tx_shift (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  spx_link_if.tx lk
);
  spx_pkg::spx_state_e st; // Sequencer state
  logic [8:0] sh;          // Bits still to send
  logic [3:0] cnt;         // Bit counter
  logic par;               // Running parity

  assign lk.tx_busy = (st != spx_pkg::ST_IDLE);

  // Frame sequencer, line changes only on a bit strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st <= spx_pkg::ST_IDLE;
      sh <= '0;
      cnt <= '0;
      par <= 1'h0;
      lk.tx_line <= spx_pkg::LINE_IDLE;
      lk.tx_done <= 1'h0;
    end
    else
    begin
      lk.tx_done <= 1'h0;
      case (st)
        spx_pkg::ST_IDLE:
        begin
          // Load when idle; line rests high
          if (lk.tx_load)
          begin
            sh <= lk.tx_word;
            par <= lk.par_odd;
            st <= spx_pkg::ST_START;
          end
        end
        spx_pkg::ST_START:
        begin
          if (lk.tick_tx)
          begin
            // Start bit first
            lk.tx_line <= 1'h0;
            cnt <= '0;
            st <= spx_pkg::ST_DATA;
          end
        end
        spx_pkg::ST_DATA:
        begin
          if (lk.tick_tx)
          begin
            // Least significant bit first
            lk.tx_line <= sh[0];
            par <= par ^ sh[0];
            sh <= {1'h0, sh[8:1]};
            cnt <= cnt + 4'h1;
            if (cnt == lk.nbits - 4'h1)
            begin
              st <= lk.par_en ? spx_pkg::ST_PAR : spx_pkg::ST_STOP;
            end
          end
        end
        spx_pkg::ST_PAR:
        begin
          if (lk.tick_tx)
          begin
            // Parity between last data and first stop
            lk.tx_line <= par;
            st <= spx_pkg::ST_STOP;
          end
        end
        spx_pkg::ST_STOP:
        begin
          if (lk.tick_tx)
          begin
            lk.tx_line <= spx_pkg::LINE_IDLE;
            cnt <= (st == spx_pkg::ST_STOP && cnt >= 4'h8) ? '0 : cnt;
          end
        end
        default:
        begin
          st <= spx_pkg::ST_IDLE;
        end
      endcase
      // Stop bit period counting, apart from the data counter use
      if (st == spx_pkg::ST_PAR || (st == spx_pkg::ST_DATA && lk.tick_tx &&
          cnt == lk.nbits - 4'h1 && !lk.par_en))
      begin
        cnt <= '0;
      end
      if (st == spx_pkg::ST_STOP && lk.tick_tx)
      begin
        cnt <= cnt + 4'h1;
        if (cnt == (lk.stop2 ? 4'h2 : 4'h1))
        begin
          // Whole frame out
          lk.tx_done <= 1'h1;
          cnt <= '0;
          st <= spx_pkg::ST_IDLE;
        end
      end
    end
  end
endmodule : spx_tx_shift
